// file: common/lcd_regs_pkg.sv
package lcd_regs_pkg;
  // Register indices reached through the index pointer
  localparam logic [4:0] IDX_HTOTAL   = 5'h00;
  localparam logic [4:0] IDX_HDISP    = 5'h01;
  localparam logic [4:0] IDX_MAXRAST  = 5'h09;
  localparam logic [4:0] IDX_CURSTART = 5'h0a;
  localparam logic [4:0] IDX_CUREND   = 5'h0b;
  localparam logic [4:0] IDX_SAH      = 5'h0c;
  localparam logic [4:0] IDX_SAL      = 5'h0d;
  localparam logic [4:0] IDX_CAH      = 5'h0e;
  localparam logic [4:0] IDX_CAL      = 5'h0f;
  localparam logic [4:0] IDX_VWIDTH   = 5'h12;
  localparam logic [4:0] IDX_DUTYH    = 5'h13;
  localparam logic [4:0] IDX_DUTYL    = 5'h14;
  localparam logic [4:0] IDX_SCROLL   = 5'h15;
  localparam logic [4:0] IDX_MODE     = 5'h16;
  // Field positions
  localparam int BLINK_HI_BIT = 6;
  localparam int BLINK_LO_BIT = 5;
  localparam int MODE_ATTR    = 0;
  localparam int MODE_BLINK   = 1;
  localparam int MODE_WIDE    = 2;
  localparam int MODE_DISP    = 4;
  // Blink periods in frames
  localparam int BLINK_SLOW_FRAMES = 64;
  localparam int BLINK_FAST_FRAMES = 32;
  // Reset value of every control register
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Blink control encodings
  localparam logic [1:0] BLINK_STEADY = 2'h0;
  localparam logic [1:0] BLINK_OFF    = 2'h1;
  localparam logic [1:0] BLINK_FAST   = 2'h2;
  localparam logic [1:0] BLINK_SLOW   = 2'h3;

  // Host bus request group
  typedef struct packed {
    logic       cs_n;
    logic       register_select;
    logic       wr_n;
    logic       rd_n;
    logic [7:0] wdata;
  } host_req_s;

  // External mode pins
  typedef struct packed {
    logic display_on;
    logic double_width;
    logic blink_enable;
    logic attribute_enable;
  } mode_pins_s;

  // Decoded configuration toward the timing logic
  typedef struct packed {
    logic [7:0]  horizontal_total_count;
    logic [7:0]  horizontal_displayed_count;
    logic [4:0]  max_raster_per_row;
    logic [4:0]  cursor_start_raster;
    logic [4:0]  cursor_end_raster;
    logic [15:0] display_start_addr;
    logic [15:0] cursor_addr;
    logic [7:0]  virtual_row_width;
    logic [8:0]  duty_rasters;
    logic [4:0]  scroll_start_raster;
  } timing_cfg_s;
endpackage : lcd_regs_pkg

// file: core/lcd_timing_register_bank.sv
// Overview of operation
// - Five-bit write-only index selects the control register
// - Only start and cursor addresses are readable
// - Blink code 00 steady, 01 cursor hidden
// - Blink 10 every 32, 11 every 64 frames
// - Effective mode is pin OR register bit
// - Writes to unassigned indices change nothing
// - Eight-bit horizontal total count
// - Eight-bit horizontal displayed count
// - Five-bit maximum raster per row
// - Cursor start: five raster bits plus blink
// - Five-bit cursor end raster
// - Sixteen-bit display start from two bytes
// - Sixteen-bit cursor address from two bytes
// - Eight-bit virtual row width
// - Nine-bit duty raster count from two registers
// - Five-bit scroll start raster
// - Mode bits: attr0, blink1, wide2, display4
// - Double width only in character mode
// - Attributes only in character mode
`timescale 1ns/1ns
`default_nettype none
module lcd_timing_register_bank (
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  input  wire lcd_regs_pkg::host_req_s    host_req,
  input  wire lcd_regs_pkg::mode_pins_s   mode_pins,
  input  wire logic                       graphic_mode,
  input  wire logic                       frame_pulse,
  output logic [7:0]                      rdata,
  output logic                            rdata_oe,
  output lcd_regs_pkg::timing_cfg_s       timing_cfg,
  output lcd_regs_pkg::mode_pins_s        mode_eff,
  output logic                            cursor_visible
);
  import lcd_regs_pkg::*;

  // Synchronisers for pin inputs
  host_req_s  req_s1;
  host_req_s  req_s2;
  mode_pins_s pins_s1;
  mode_pins_s pins_s2;
  logic       gfx_s1;
  logic       gfx_s2;
  logic       frm_s1;
  logic       frm_s2;
  logic       frm_d;
  logic       wr_d;

  // Register store
  logic [4:0] register_index_pointer;
  logic [7:0] horizontal_total_count;
  logic [7:0] horizontal_displayed_count;
  logic [4:0] max_raster_per_row;
  logic [6:0] cursor_start_and_blink;
  logic [4:0] cursor_end_raster;
  logic [7:0] display_start_addr_high;
  logic [7:0] display_start_addr_low;
  logic [7:0] cursor_addr_high;
  logic [7:0] cursor_addr_low;
  logic [7:0] virtual_row_width;
  logic [7:0] duty_rasters_high;
  logic [7:0] duty_rasters_low;
  logic [4:0] scroll_start_raster;
  logic [4:0] display_mode_control;
  logic [5:0] frame_count;

  // Next values
  logic [4:0] next_register_index_pointer;
  logic [7:0] next_horizontal_total_count;
  logic [7:0] next_horizontal_displayed_count;
  logic [4:0] next_max_raster_per_row;
  logic [6:0] next_cursor_start_and_blink;
  logic [4:0] next_cursor_end_raster;
  logic [7:0] next_display_start_addr_high;
  logic [7:0] next_display_start_addr_low;
  logic [7:0] next_cursor_addr_high;
  logic [7:0] next_cursor_addr_low;
  logic [7:0] next_virtual_row_width;
  logic [7:0] next_duty_rasters_high;
  logic [7:0] next_duty_rasters_low;
  logic [4:0] next_scroll_start_raster;
  logic [4:0] next_display_mode_control;
  logic [7:0] next_rdata;
  logic       next_rdata_oe;
  timing_cfg_s next_timing_cfg;
  mode_pins_s  next_mode_eff;
  logic        next_cursor_visible;
  logic [5:0]  next_frame_count;
  logic        wr_edge;
  logic        rd_act;
  logic [1:0]  blink_code;

  // Two-stage capture of all pin inputs
  always_ff @(posedge clk_sys) begin
    req_s1  <= host_req;
    req_s2  <= req_s1;
    pins_s1 <= mode_pins;
    pins_s2 <= pins_s1;
    gfx_s1  <= graphic_mode;
    gfx_s2  <= gfx_s1;
    frm_s1  <= frame_pulse;
    frm_s2  <= frm_s1;
  end

  // Strobe qualifiers: write acts once on the falling write edge
  always_comb begin
    wr_edge = !req_s2.cs_n && !req_s2.wr_n && wr_d;
    rd_act  = !req_s2.cs_n && !req_s2.rd_n && req_s2.register_select;
    blink_code = cursor_start_and_blink[BLINK_HI_BIT:BLINK_LO_BIT];
  end

  // Register write decode
  always_comb begin
    next_register_index_pointer     = register_index_pointer;
    next_horizontal_total_count     = horizontal_total_count;
    next_horizontal_displayed_count = horizontal_displayed_count;
    next_max_raster_per_row         = max_raster_per_row;
    next_cursor_start_and_blink     = cursor_start_and_blink;
    next_cursor_end_raster          = cursor_end_raster;
    next_display_start_addr_high    = display_start_addr_high;
    next_display_start_addr_low     = display_start_addr_low;
    next_cursor_addr_high           = cursor_addr_high;
    next_cursor_addr_low            = cursor_addr_low;
    next_virtual_row_width          = virtual_row_width;
    next_duty_rasters_high          = duty_rasters_high;
    next_duty_rasters_low           = duty_rasters_low;
    next_scroll_start_raster        = scroll_start_raster;
    next_display_mode_control       = display_mode_control;
    if (wr_edge && !req_s2.register_select) begin
      // Index pointer write
      next_register_index_pointer = req_s2.wdata[4:0];
    end else if (wr_edge) begin
      case (register_index_pointer)
        IDX_HTOTAL:   next_horizontal_total_count = req_s2.wdata;
        IDX_HDISP:    next_horizontal_displayed_count = req_s2.wdata;
        IDX_MAXRAST:  next_max_raster_per_row = req_s2.wdata[4:0];
        IDX_CURSTART: next_cursor_start_and_blink = req_s2.wdata[6:0];
        IDX_CUREND:   next_cursor_end_raster = req_s2.wdata[4:0];
        IDX_SAH:      next_display_start_addr_high = req_s2.wdata;
        IDX_SAL:      next_display_start_addr_low = req_s2.wdata;
        IDX_CAH:      next_cursor_addr_high = req_s2.wdata;
        IDX_CAL:      next_cursor_addr_low = req_s2.wdata;
        IDX_VWIDTH:   next_virtual_row_width = req_s2.wdata;
        IDX_DUTYH:    next_duty_rasters_high = req_s2.wdata;
        IDX_DUTYL:    next_duty_rasters_low = req_s2.wdata;
        IDX_SCROLL:   next_scroll_start_raster = req_s2.wdata[4:0];
        IDX_MODE:     next_display_mode_control = req_s2.wdata[4:0];
        default:      ; // Unassigned index: write dropped
      endcase
    end
  end

  // Read path and derived outputs
  always_comb begin
    next_rdata    = RESET_BYTE;
    next_rdata_oe = rd_act;
    if (rd_act) begin
      case (register_index_pointer)
        IDX_SAH: next_rdata = display_start_addr_high;
        IDX_SAL: next_rdata = display_start_addr_low;
        IDX_CAH: next_rdata = cursor_addr_high;
        IDX_CAL: next_rdata = cursor_addr_low;
        default: next_rdata = RESET_BYTE; // Write-only or unassigned
      endcase
    end
    next_timing_cfg.horizontal_total_count     = horizontal_total_count;
    next_timing_cfg.horizontal_displayed_count = horizontal_displayed_count;
    next_timing_cfg.max_raster_per_row         = max_raster_per_row;
    next_timing_cfg.cursor_start_raster        = cursor_start_and_blink[4:0];
    next_timing_cfg.cursor_end_raster          = cursor_end_raster;
    next_timing_cfg.display_start_addr = {display_start_addr_high, display_start_addr_low};
    next_timing_cfg.cursor_addr        = {cursor_addr_high, cursor_addr_low};
    next_timing_cfg.virtual_row_width   = virtual_row_width;
    next_timing_cfg.duty_rasters        = {duty_rasters_high[0], duty_rasters_low};
    next_timing_cfg.scroll_start_raster = scroll_start_raster;
    // Pin OR register; wide and attributes gated off in graphic mode
    next_mode_eff.display_on   = pins_s2.display_on | display_mode_control[MODE_DISP];
    next_mode_eff.blink_enable = pins_s2.blink_enable
                                 | display_mode_control[MODE_BLINK];
    next_mode_eff.double_width = (pins_s2.double_width
                                  | display_mode_control[MODE_WIDE]) & !gfx_s2;
    next_mode_eff.attribute_enable = (pins_s2.attribute_enable
                                      | display_mode_control[MODE_ATTR]) & !gfx_s2;
    // Cursor blink selection
    case (blink_code)
      BLINK_STEADY: next_cursor_visible = 1'b1;
      BLINK_OFF:    next_cursor_visible = 1'b0;
      BLINK_FAST:   next_cursor_visible = !frame_count[4];
      default:      next_cursor_visible = !frame_count[5];
    endcase
  end

  // Frame counter for blink periods
  always_comb begin
    next_frame_count = frame_count;
    if (frm_s2 && !frm_d) begin
      next_frame_count = frame_count + 6'h1;
    end
  end

  // State registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      register_index_pointer     <= 5'h00;
      horizontal_total_count     <= RESET_BYTE;
      horizontal_displayed_count <= RESET_BYTE;
      max_raster_per_row         <= 5'h00;
      cursor_start_and_blink     <= 7'h00;
      cursor_end_raster          <= 5'h00;
      display_start_addr_high    <= RESET_BYTE;
      display_start_addr_low     <= RESET_BYTE;
      cursor_addr_high           <= RESET_BYTE;
      cursor_addr_low            <= RESET_BYTE;
      virtual_row_width          <= RESET_BYTE;
      duty_rasters_high          <= RESET_BYTE;
      duty_rasters_low           <= RESET_BYTE;
      scroll_start_raster        <= 5'h00;
      display_mode_control       <= 5'h00;
      frame_count                <= 6'h00;
      wr_d                       <= 1'b0; // Strobe low at release waits for a rise
      frm_d                      <= 1'b0;
      rdata                      <= RESET_BYTE;
      rdata_oe                   <= 1'b0;
      timing_cfg                 <= '0;
      mode_eff                   <= '0;
      cursor_visible             <= 1'b0;
    end else begin
      register_index_pointer     <= next_register_index_pointer;
      horizontal_total_count     <= next_horizontal_total_count;
      horizontal_displayed_count <= next_horizontal_displayed_count;
      max_raster_per_row         <= next_max_raster_per_row;
      cursor_start_and_blink     <= next_cursor_start_and_blink;
      cursor_end_raster          <= next_cursor_end_raster;
      display_start_addr_high    <= next_display_start_addr_high;
      display_start_addr_low     <= next_display_start_addr_low;
      cursor_addr_high           <= next_cursor_addr_high;
      cursor_addr_low            <= next_cursor_addr_low;
      virtual_row_width          <= next_virtual_row_width;
      duty_rasters_high          <= next_duty_rasters_high;
      duty_rasters_low           <= next_duty_rasters_low;
      scroll_start_raster        <= next_scroll_start_raster;
      display_mode_control       <= next_display_mode_control;
      frame_count                <= next_frame_count;
      wr_d                       <= req_s2.cs_n | req_s2.wr_n;
      frm_d                      <= frm_s2;
      rdata                      <= next_rdata;
      rdata_oe                   <= next_rdata_oe;
      timing_cfg                 <= next_timing_cfg;
      mode_eff                   <= next_mode_eff;
      cursor_visible             <= next_cursor_visible;
    end
  end

  // Checks
  property p_cs_ignore;
    @(posedge clk_sys) disable iff (sys_rst)
      req_s2.cs_n |=> $stable(register_index_pointer) && $stable(display_mode_control);
  endproperty
  a_cs_ignore: assert property (p_cs_ignore) else $error("write taken with cs high");

  property p_index_write;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_edge && !req_s2.register_select) |=> register_index_pointer == $past(req_s2.wdata[4:0]);
  endproperty
  a_index_write: assert property (p_index_write) else $error("index not loaded");

  property p_read_wo_zero;
    @(posedge clk_sys) disable iff (sys_rst)
      (rd_act && register_index_pointer == IDX_MODE) |=> rdata == 8'h00 && rdata_oe;
  endproperty
  a_read_wo_zero: assert property (p_read_wo_zero) else $error("write-only read leaked");

  property p_read_sal;
    @(posedge clk_sys) disable iff (sys_rst)
      (rd_act && register_index_pointer == IDX_SAL) |=> rdata == $past(display_start_addr_low);
  endproperty
  a_read_sal: assert property (p_read_sal) else $error("start low read wrong");

  property p_blink_off;
    @(posedge clk_sys) disable iff (sys_rst)
      (blink_code == BLINK_OFF) |=> !cursor_visible;
  endproperty
  a_blink_off: assert property (p_blink_off) else $error("cursor shown when off");

  property p_mode_or;
    @(posedge clk_sys) disable iff (sys_rst)
      (pins_s2.display_on || display_mode_control[MODE_DISP]) |=> mode_eff.display_on;
  endproperty
  a_mode_or: assert property (p_mode_or) else $error("mode OR lost");

  property p_unassigned;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_edge && req_s2.register_select && register_index_pointer == 5'h10)
        |=> $stable(timing_cfg) ##1 $stable(timing_cfg);
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("unassigned write had effect");

  property p_wide_gfx;
    @(posedge clk_sys) disable iff (sys_rst)
      gfx_s2 |=> !mode_eff.double_width && !mode_eff.attribute_enable;
  endproperty
  a_wide_gfx: assert property (p_wide_gfx) else $error("wide or attr in graphic");

  // Strobe edge, read path, blink phase and field assembly
  property p_write_once;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_edge |=> !wr_edge;
  endproperty
  a_write_once: assert property (p_write_once) else $error("write taken twice");

  property p_read_oe;
    @(posedge clk_sys) disable iff (sys_rst)
      1'b1 |=> rdata_oe == $past(rd_act);
  endproperty
  a_read_oe: assert property (p_read_oe) else $error("read enable wrong");

  property p_read_cah;
    @(posedge clk_sys) disable iff (sys_rst)
      (rd_act && register_index_pointer == IDX_CAH) |=> rdata == $past(cursor_addr_high);
  endproperty
  a_read_cah: assert property (p_read_cah) else $error("cursor high read wrong");

  property p_blink_steady;
    @(posedge clk_sys) disable iff (sys_rst)
      (blink_code == BLINK_STEADY) |=> cursor_visible;
  endproperty
  a_blink_steady: assert property (p_blink_steady) else $error("steady cursor hidden");

  property p_blink_fast;
    @(posedge clk_sys) disable iff (sys_rst)
      (blink_code == BLINK_FAST) |=> cursor_visible == !$past(frame_count[4]);
  endproperty
  a_blink_fast: assert property (p_blink_fast) else $error("fast blink phase wrong");

  property p_blink_slow;
    @(posedge clk_sys) disable iff (sys_rst)
      (blink_code == BLINK_SLOW) |=> cursor_visible == !$past(frame_count[5]);
  endproperty
  a_blink_slow: assert property (p_blink_slow) else $error("slow blink phase wrong");

  property p_frame_step;
    @(posedge clk_sys) disable iff (sys_rst)
      (frm_s2 && !frm_d) |=> frame_count == 6'($past(frame_count) + 6'h1);
  endproperty
  a_frame_step: assert property (p_frame_step) else $error("frame not counted");

  property p_mode_blink;
    @(posedge clk_sys) disable iff (sys_rst)
      (pins_s2.blink_enable || display_mode_control[MODE_BLINK]) |=> mode_eff.blink_enable;
  endproperty
  a_mode_blink: assert property (p_mode_blink) else $error("blink enable OR lost");

  property p_mode_load;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_edge && req_s2.register_select && register_index_pointer == IDX_MODE)
        |=> display_mode_control == $past(req_s2.wdata[4:0]);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode register not loaded");

  property p_start_addr;
    @(posedge clk_sys) disable iff (sys_rst)
      1'b1 |=> timing_cfg.display_start_addr
        == $past({display_start_addr_high, display_start_addr_low});
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start address pairing wrong");

  property p_duty;
    @(posedge clk_sys) disable iff (sys_rst)
      1'b1 |=> timing_cfg.duty_rasters
        == $past({duty_rasters_high[0], duty_rasters_low});
  endproperty
  a_duty: assert property (p_duty) else $error("duty count pairing wrong");
endmodule : lcd_timing_register_bank
`default_nettype wire

// file: verif/host_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host processor on the parallel bus, strobes changed only after a clock edge
module host_cpu_model (
  input  wire logic                     clk_sys,  // System clock
  input  wire logic [7:0]               rdata,    // Read data from device
  input  wire logic                     rdata_oe, // Read drive enable
  output var  lcd_regs_pkg::host_req_s  host_req  // Bus request group
);
  import lcd_regs_pkg::*;

  // Idle bus at time zero
  initial begin
    host_req = '{cs_n: 1'b1, register_select: 1'b0, wr_n: 1'b1, rd_n: 1'b1, wdata: 8'h00};
  end

  // One write strobe; counts are passed raw, already minus one
  task automatic xfer(input logic cs_n, input logic rs, input logic [7:0] d);
    @(posedge clk_sys);
    host_req.cs_n            <= cs_n;
    host_req.register_select <= rs;
    host_req.wdata           <= d;
    host_req.wr_n            <= 1'b0;
    repeat (4) @(posedge clk_sys);
    host_req.wr_n            <= 1'b1;
    host_req.cs_n            <= 1'b1;
    host_req.wdata           <= ~d; // Released data no longer valid
    repeat (3) @(posedge clk_sys);
  endtask : xfer

  // One read strobe, answer taken while the strobe is still held
  task automatic rd(input logic rs, output logic [7:0] d, output logic oe);
    @(posedge clk_sys);
    host_req.cs_n            <= 1'b0;
    host_req.register_select <= rs;
    host_req.rd_n            <= 1'b0;
    repeat (4) @(posedge clk_sys);
    d  = rdata;
    oe = rdata_oe;
    host_req.rd_n            <= 1'b1;
    host_req.cs_n            <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : rd

  // Index first, then data
  task automatic put_reg(input logic [4:0] idx, input logic [7:0] d);
    xfer(1'b0, 1'b0, {3'h0, idx});
    xfer(1'b0, 1'b1, d);
  endtask : put_reg

  // Index first, then read of the indexed register
  task automatic get_reg(input logic [4:0] idx, output logic [7:0] d, output logic oe);
    xfer(1'b0, 1'b0, {3'h0, idx});
    rd(1'b1, d, oe);
  endtask : get_reg
endmodule : host_cpu_model
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lcd_regs_pkg::*;
  logic        clk_sys      = 1'b0;  // System clock
  logic        sys_rst      = 1'b1;  // Sync reset
  mode_pins_s  mode_pins    = '0;    // External mode pins
  logic        graphic_mode = 1'b0;  // Graphic mode pin
  logic        frame_pulse  = 1'b0;  // Frame tick
  host_req_s   host_req;             // Bus from host model
  logic [7:0]  rdata;                // Read data
  logic        rdata_oe;             // Read drive enable
  timing_cfg_s timing_cfg;           // Decoded fields
  mode_pins_s  mode_eff;             // Effective mode
  mode_pins_s  em;                   // Expected mode
  logic        cursor_visible;       // Cursor state
  int          mismatches   = 0;
  int          checked      = 0;
  int          regs [32];            // Reference register contents
  logic [7:0]  rnd          = 8'h41; // Random state
  logic [7:0]  rd_v;                 // Read value
  logic        oe_v;                 // Read enable seen
  logic        vis0;                 // Cursor state before frames

  // Clock
  always #50 clk_sys = ~clk_sys;

  lcd_timing_register_bank dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .host_req(host_req), .mode_pins(mode_pins),
    .graphic_mode(graphic_mode), .frame_pulse(frame_pulse), .rdata(rdata),
    .rdata_oe(rdata_oe), .timing_cfg(timing_cfg), .mode_eff(mode_eff),
    .cursor_visible(cursor_visible));

  host_cpu_model host_u (
    .clk_sys(clk_sys), .rdata(rdata), .rdata_oe(rdata_oe), .host_req(host_req));

  // Random source
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Implemented indices
  function automatic bit impl(input int i);
    return (i <= 1) || (i >= 9 && i <= 15) || (i >= 18 && i <= 22);
  endfunction : impl

  // Expected decoded fields from the reference contents
  function automatic timing_cfg_s exp_cfg();
    timing_cfg_s e;
    e.horizontal_total_count     = 8'(regs[0]);
    e.horizontal_displayed_count = 8'(regs[1]);
    e.max_raster_per_row         = 5'(regs[9]);
    e.cursor_start_raster        = 5'(regs[10]);
    e.cursor_end_raster          = 5'(regs[11]);
    e.display_start_addr         = {8'(regs[12]), 8'(regs[13])};
    e.cursor_addr                = {8'(regs[14]), 8'(regs[15])};
    e.virtual_row_width          = 8'(regs[18]);
    e.duty_rasters               = {regs[19][0], 8'(regs[20])};
    e.scroll_start_raster        = 5'(regs[21]);
    return e;
  endfunction : exp_cfg

  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("Counts: checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Write through the host and track it in the reference
  task automatic put(input int idx, input logic [7:0] d);
    host_u.put_reg(5'(idx), d);
    if (impl(idx)) regs[idx] = d;
  endtask : put

  // Frame ticks, then settling time
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      frame_pulse <= 1'b1;
      @(posedge clk_sys);
      frame_pulse <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
  endtask : frames

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    $display("BAD watchdog expected finish seen timeout");
    conclude();
  end

  // Main sequence
  initial begin
    foreach (regs[i]) regs[i] = 0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("cfg reset", 96'(timing_cfg), 96'(exp_cfg()));
    check("mode reset", 96'(mode_eff), 96'h0);
    check("oe reset", 96'(rdata_oe), 96'h0);
    $display("test reset done");
    // Every index with random data, unassigned ones included
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      put(i, rnd);
    end
    check("cfg programmed", 96'(timing_cfg), 96'(exp_cfg()));
    for (int i = 0; i < 24; i++) begin
      host_u.get_reg(5'(i), rd_v, oe_v);
      check("read data", 96'(rd_v), 96'((i >= 12 && i <= 15) ? regs[i] : 0));
      check("read enable", 96'(oe_v), 96'h1);
    end
    check("cfg after reads", 96'(timing_cfg), 96'(exp_cfg()));
    $display("test program and read done");
    // Deselected index write must not move the pointer
    host_u.xfer(1'b0, 1'b0, {3'h0, IDX_SAH});
    host_u.xfer(1'b1, 1'b0, {3'h0, IDX_SAL});
    host_u.xfer(1'b1, 1'b1, 8'ha5);
    host_u.xfer(1'b0, 1'b1, 8'h3c);
    regs[12] = 8'h3c;
    check("cfg chip select", 96'(timing_cfg), 96'(exp_cfg()));
    host_u.rd(1'b0, rd_v, oe_v);
    check("pointer read enable", 96'(oe_v), 96'h0);
    $display("test chip select done");
    // Pins OR register bits, wide and attributes gated in graphic mode
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      put(22, rnd);
      rnd = lfsr(rnd);
      @(posedge clk_sys);
      mode_pins    <= mode_pins_s'(rnd[3:0]);
      graphic_mode <= rnd[4];
      em.display_on       = rnd[3] | regs[22][MODE_DISP];
      em.double_width     = (rnd[2] | regs[22][MODE_WIDE]) & ~rnd[4];
      em.blink_enable     = rnd[1] | regs[22][MODE_BLINK];
      em.attribute_enable = (rnd[0] | regs[22][MODE_ATTR]) & ~rnd[4];
      repeat (2) @(posedge clk_sys);
      for (int w = 0; w < 8 && mode_eff !== em; w++) @(posedge clk_sys);
      check("mode", 96'(mode_eff), 96'(em));
    end
    $display("test mode done");
    // Cursor blink codes
    @(posedge clk_sys);
    mode_pins    <= '0;
    graphic_mode <= 1'b0;
    put(10, 8'h00);
    check("cursor steady", 96'(cursor_visible), 96'h1);
    put(10, 8'h20);
    check("cursor hidden", 96'(cursor_visible), 96'h0);
    put(10, 8'h40);
    vis0 = cursor_visible;
    frames(BLINK_FAST_FRAMES / 2);
    check("fast half", 96'(cursor_visible), 96'(!vis0));
    frames(BLINK_FAST_FRAMES / 2);
    check("fast full", 96'(cursor_visible), 96'(vis0));
    put(10, 8'h60);
    vis0 = cursor_visible;
    frames(BLINK_SLOW_FRAMES / 2);
    check("slow half", 96'(cursor_visible), 96'(!vis0));
    frames(BLINK_SLOW_FRAMES / 2);
    check("slow full", 96'(cursor_visible), 96'(vis0));
    $display("test blink done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
